// ---- host_port_pkg.sv ----
/*
 * Shared constants and carrier types for the strobe-style host bus slave port.
 * Assumes a single 100 MHz system clock and a synchronous active-low reset.
 */
package host_port_pkg;

	// ************************************************************
	// Straps and configuration
	// ************************************************************
	localparam logic [2:0] MODE_STROBE_BUS   = 3'h4;
	localparam logic       STALL_POL_RESET   = 1'b0;
	localparam logic       ENDIAN_LITTLE     = 1'b0;

	// ************************************************************
	// Address space
	// ************************************************************
	localparam int         ADDR_W            = 17;
	localparam int         DATA_W            = 16;
	localparam int         WINDOW_BYTES      = 262144;
	localparam int         BLOCK_BYTES       = 131072;
	localparam int         REG_WORDS_LOG2    = 5;
	localparam int         BUF_WORDS_LOG2    = 10;

	// ************************************************************
	// Timing
	// ************************************************************
	localparam int         CLK_PERIOD_NS     = 10;
	localparam int         REFRESH_PERIOD    = 8;
	localparam logic [1:0] BCLK_DIV_RESET    = 2'h0;
	localparam logic [3:0] HOLD_RESET        = 4'h0;

	typedef enum logic [2:0] {
		ST_IDLE  = 3'b000,
		ST_ARB   = 3'b001,
		ST_XFER  = 3'b011,
		ST_DONE  = 3'b010,
		ST_END   = 3'b110
	} port_state_t;

	typedef struct packed {
		logic [ADDR_W-1:0] addr;
		logic              mem_sel;
		logic              write;
		logic [1:0]        lanes;
	} host_req_t;

endpackage : host_port_pkg

// ---- lane_mem.sv ----
/*
 * Small byte-lane memory with registered read data.
 * Assumes one clock, one port, writes and reads never in the same cycle.
 */
`timescale 1ns/10ps
module lane_mem #(
	parameter int ADDR_BITS = 10,
	parameter int DATA_BITS = 16
) (
	input  wire logic                 sys_clk,
	input  wire logic                 en,
	input  wire logic                 we,
	input  wire logic [1:0]           lanes,
	input  wire logic [ADDR_BITS-1:0] addr,
	input  wire logic [DATA_BITS-1:0] wdata,
	output logic      [DATA_BITS-1:0] rdata
);
	logic [DATA_BITS-1:0] mem [0:(1<<ADDR_BITS)-1];

	always_ff @(posedge sys_clk)
	begin
		if (en && we && lanes[0])
			mem[addr][7:0] <= wdata[7:0];
		if (en && we && lanes[1])
			mem[addr][15:8] <= wdata[15:8];
		if (en && !we)
			rdata <= mem[addr];
	end
endmodule : lane_mem

// ---- host_bus_slave.sv ----
/*
 * Strobe-based 16-bit host bus slave port with wait handshake,
 * byte steering, register / display buffer split and refresh arbitration.
 * Assumes host pins are asynchronous to sys_clk; straps are stable at reset release.
 */
`timescale 1ns/10ps
module host_bus_slave #(
	parameter int REFRESH_CYCLES = host_port_pkg::REFRESH_PERIOD
) (
	input  wire logic                              sys_clk,
	input  wire logic                              rstn,
	input  wire logic [2:0]                        bus_mode_straps,
	input  wire logic                              endian_strap,
	input  wire logic                              stall_polarity_strap,
	input  wire logic [1:0]                        bclk_div_straps,
	input  wire logic [host_port_pkg::ADDR_W-1:0]  host_address_in,
	input  wire logic                              mem_reg_sel,
	input  wire logic                              host_display_select_n,
	input  wire logic                              read_strobe_n,
	input  wire logic                              low_byte_write_n,
	input  wire logic                              high_byte_strobe_n,
	input  wire logic                              bus_start_in,
	input  wire logic                              rw_dir_in,
	input  wire logic [host_port_pkg::DATA_W-1:0]  host_data_bus_in,
	output logic      [host_port_pkg::DATA_W-1:0]  host_data_bus_out,
	output logic                                   host_data_bus_oe,
	output logic                                   host_wait,
	output logic                                   port_enabled,
	output logic                                   bclk_tick
);
	localparam int RW = host_port_pkg::REG_WORDS_LOG2;
	localparam int BW = host_port_pkg::BUF_WORDS_LOG2;

	// ************************************************************
	// Lane decode
	// ************************************************************
	function automatic logic [1:0] lane_decode(input logic hbe_n, input logic a0);
		logic [1:0] l;
		l = 2'h0;
		if (!hbe_n && !a0)
			l = 2'h3;
		else if (!hbe_n && a0)
			l = 2'h2;
		else if (hbe_n && !a0)
			l = 2'h1;
		else
			l = 2'h2;
		return l;
	endfunction : lane_decode

	// ************************************************************
	// Strap capture at release
	// ************************************************************
	logic       rst_seen_q, rst_seen_d;
	logic       enabled_q, enabled_d;
	logic       wpol_q, wpol_d;
	logic [1:0] div_q, div_d;

	always_comb
	begin
		rst_seen_d = 1'b1;
		enabled_d  = enabled_q;
		wpol_d     = wpol_q;
		div_d      = div_q;
		if (!rst_seen_q)
		begin
			// Little-endian strap is the only order served; big-endian disables the port
			enabled_d = (bus_mode_straps == host_port_pkg::MODE_STROBE_BUS) &&
				(endian_strap == host_port_pkg::ENDIAN_LITTLE);
			wpol_d    = stall_polarity_strap;
			div_d     = bclk_div_straps;
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			rst_seen_q <= 1'b0;
			enabled_q  <= 1'b0;
			wpol_q     <= host_port_pkg::STALL_POL_RESET;
			div_q      <= host_port_pkg::BCLK_DIV_RESET;
		end
		else
		begin
			rst_seen_q <= rst_seen_d;
			enabled_q  <= enabled_d;
			wpol_q     <= wpol_d;
			div_q      <= div_d;
		end
	end

	// ************************************************************
	// Bus clock divider and refresh slot
	// ************************************************************
	logic [1:0] dcnt_q, dcnt_d;
	logic       tick_q, tick_d;
	logic [7:0] rcnt_q, rcnt_d;
	logic       refresh;

	always_comb
	begin
		tick_d = (dcnt_q == div_q);
		dcnt_d = tick_d ? 2'h0 : dcnt_q + 2'h1;
		rcnt_d = rcnt_q;
		if (tick_q)
			rcnt_d = (rcnt_q == 8'(REFRESH_CYCLES - 1)) ? 8'h00 : rcnt_q + 8'h01;
	end
	assign refresh = (rcnt_q == 8'h00);

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			dcnt_q <= 2'h0;
			tick_q <= 1'b0;
			rcnt_q <= 8'h00;
		end
		else
		begin
			dcnt_q <= dcnt_d;
			tick_q <= tick_d;
			rcnt_q <= rcnt_d;
		end
	end

	// ************************************************************
	// Strobe synchronisers
	// ************************************************************
	logic [2:0] sy1_q, sy2_q;

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			sy1_q <= 3'h7;
			sy2_q <= 3'h7;
		end
		else
		begin
			sy1_q <= {host_display_select_n, read_strobe_n, low_byte_write_n};
			sy2_q <= sy1_q;
		end
	end

	// Address, data and the high byte strobe are stable while strobes are low, so only select, read and low write strobes are synced
	logic cs_act, rd_act, wr_act;
	assign cs_act = !sy2_q[2] && enabled_q;
	assign rd_act = cs_act && !sy2_q[1];
	assign wr_act = cs_act && !sy2_q[0];

	// ************************************************************
	// Access sequencer
	// ************************************************************
	host_port_pkg::port_state_t st_q, st_d;
	host_port_pkg::host_req_t   req_q, req_d;
	logic [15:0] wdat_q, wdat_d, rdat_q, rdat_d;
	logic        wait_q, wait_d;
	logic        oe_q, oe_d;
	logic        mem_en, reg_en;
	logic [15:0] reg_rd, buf_rd;

	always_comb
	begin
		st_d   = st_q;
		req_d  = req_q;
		wdat_d = wdat_q;
		rdat_d = rdat_q;
		mem_en = 1'b0;
		reg_en = 1'b0;
		case (st_q)
			host_port_pkg::ST_IDLE:
				// Direction pins are never looked at here
				if (rd_act || wr_act)
				begin
					req_d.addr    = host_address_in;
					req_d.mem_sel = mem_reg_sel;
					req_d.write   = wr_act;
					req_d.lanes   = lane_decode(high_byte_strobe_n, host_address_in[0]);
					wdat_d        = host_data_bus_in;
					st_d          = host_port_pkg::ST_ARB;
				end
			host_port_pkg::ST_ARB:
				if (!refresh)
					st_d = host_port_pkg::ST_XFER;
			host_port_pkg::ST_XFER:
			begin
				mem_en = req_q.mem_sel;
				reg_en = !req_q.mem_sel;
				st_d   = host_port_pkg::ST_DONE;
			end
			host_port_pkg::ST_DONE:
			begin
				rdat_d = req_q.mem_sel ? buf_rd : reg_rd;
				st_d   = host_port_pkg::ST_END;
			end
			host_port_pkg::ST_END:
				if (!rd_act && !wr_act)
					st_d = host_port_pkg::ST_IDLE;
			default:
				st_d = host_port_pkg::ST_IDLE;
		endcase
		// Wait stands from strobe detection until data is ready or taken
		wait_d = (rd_act || wr_act) && (st_d != host_port_pkg::ST_END);
		oe_d   = !sy2_q[2] && !sy2_q[1] && enabled_q;
	end

	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
		begin
			st_q   <= host_port_pkg::ST_IDLE;
			req_q  <= '0;
			wdat_q <= 16'h0000;
			rdat_q <= 16'h0000;
			wait_q <= 1'b0;
			oe_q   <= 1'b0;
		end
		else
		begin
			st_q   <= st_d;
			req_q  <= req_d;
			wdat_q <= wdat_d;
			rdat_q <= rdat_d;
			wait_q <= wait_d;
			oe_q   <= oe_d;
		end
	end

	// ************************************************************
	// Register and display buffer storage
	// ************************************************************
	lane_mem #(.ADDR_BITS(RW), .DATA_BITS(16)) reg_file (
		.sys_clk (sys_clk),
		.en      (reg_en),
		.we      (req_q.write),
		.lanes   (req_q.lanes),
		.addr    (req_q.addr[RW:1]),
		.wdata   (wdat_q),
		.rdata   (reg_rd)
	);

	lane_mem #(.ADDR_BITS(BW), .DATA_BITS(16)) disp_buf (
		.sys_clk (sys_clk),
		.en      (mem_en),
		.we      (req_q.write),
		.lanes   (req_q.lanes),
		.addr    (req_q.addr[BW:1]),
		.wdata   (wdat_q),
		.rdata   (buf_rd)
	);

	// ************************************************************
	// Outputs
	// ************************************************************
	// Odd-byte read with the high byte strobe high returns the byte on both lanes so an 8-bit host sees it low
	logic [15:0] dout_q;
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			dout_q <= 16'h0000;
		else if (req_q.lanes == 2'h2 && high_byte_strobe_n)
			dout_q <= {rdat_d[15:8], rdat_d[15:8]};
		else
			dout_q <= rdat_d;
	end

	// Wait level is inverted by strap; active low is the normal case
	logic wait_pin_q;
	always_ff @(posedge sys_clk)
	begin
		if (!rstn)
			wait_pin_q <= 1'b1;
		else
			wait_pin_q <= wpol_q ? wait_d : !wait_d;
	end

	assign host_data_bus_out = dout_q;
	assign host_data_bus_oe  = oe_q;
	assign host_wait         = wait_pin_q;
	assign port_enabled      = enabled_q;
	assign bclk_tick         = tick_q;

	logic unused_ok;
	assign unused_ok = bus_start_in ^ rw_dir_in ^ wait_q;
endmodule : host_bus_slave

// ---- host_bus_slave_monitor.sv ----
/* Checker for the strobe host port: wait handshake, strap catch, bus drive.
   Bound to host_bus_slave; sees its ports only, one clock domain. */
`timescale 1ns/10ps
module host_bus_slave_monitor (
	input wire logic       sys_clk,
	input wire logic       rstn,
	input wire logic [2:0] bus_mode_straps,
	input wire logic       endian_strap,
	input wire logic       stall_polarity_strap,
	input wire logic       host_display_select_n,
	input wire logic       read_strobe_n,
	input wire logic       low_byte_write_n,
	input wire logic       host_data_bus_oe,
	input wire logic       host_wait,
	input wire logic       port_enabled
);
	logic pol_q;
	logic [2:0] up_q;
	logic live;
	logic wait_on;
	// Live only once the caught polarity has settled
	assign live    = up_q[2];
	assign wait_on = (host_wait == pol_q);
	always_ff @(posedge sys_clk)
	begin
		up_q <= rstn ? {up_q[1:0], 1'b1} : 3'h0;
		if (rstn && !up_q[0])
			pol_q <= stall_polarity_strap;
	end
	AST_RESET_WAIT: assert property (@(posedge sys_clk) !rstn |=> host_wait)
		else $error("wait not idle high after reset");
	AST_ENABLE_STRAPS: assert property (@(posedge sys_clk) disable iff (!rstn)
		(rstn && !up_q[0]) |=> port_enabled == ($past(bus_mode_straps) == 3'h4 && !$past(endian_strap)))
		else $error("port enable does not follow straps");
	AST_DISABLED_QUIET: assert property (@(posedge sys_clk) disable iff (!rstn)
		live && !port_enabled |-> !wait_on && !host_data_bus_oe) else $error("disabled port answers");
	AST_WAIT_START: assert property (@(posedge sys_clk) disable iff (!rstn)
		live && port_enabled && !host_display_select_n && $fell(read_strobe_n && low_byte_write_n)
		|-> ##[1:4] wait_on) else $error("wait not raised for access");
	AST_WAIT_MIN: assert property (@(posedge sys_clk) disable iff (!rstn)
		live && $rose(wait_on) |-> wait_on[*3]) else $error("wait released too early");
	AST_WAIT_BOUND: assert property (@(posedge sys_clk) disable iff (!rstn)
		live && $rose(wait_on) |-> ##[3:60] !wait_on) else $error("wait never released");
	AST_READ_DRIVEN: assert property (@(posedge sys_clk) disable iff (!rstn)
		live && $fell(wait_on) && !read_strobe_n |-> host_data_bus_oe) else $error("read data not driven");
	AST_WAIT_ENABLED: assert property (@(posedge sys_clk) disable iff (!rstn)
		live && wait_on |-> port_enabled) else $error("wait while disabled");
endmodule : host_bus_slave_monitor

bind host_bus_slave host_bus_slave_monitor host_bus_slave_monitor_i (.sys_clk, .rstn, .bus_mode_straps,
	.endian_strap, .stall_polarity_strap, .host_display_select_n, .read_strobe_n, .low_byte_write_n,
	.host_data_bus_oe, .host_wait, .port_enabled);

// ---- host_bus_model.sv ----
/* Host side model: one strobe access at a time, waits on the stall pin.
   Assumes the bench tells it the strapped wait polarity. */
`timescale 1ns/10ps
module host_bus_model (
	input wire logic         sys_clk,
	input wire logic         pol,
	input wire logic         host_wait,
	input wire logic [15:0]  host_data_bus_out,
	input wire logic         host_data_bus_oe,
	output logic     [16:0]  host_address_in,
	output logic             mem_reg_sel,
	output logic             host_display_select_n,
	output logic             read_strobe_n,
	output logic             low_byte_write_n,
	output logic             high_byte_strobe_n,
	output logic     [15:0]  host_data_bus_in
);
	initial
	begin
		{host_address_in, mem_reg_sel, host_data_bus_in} = '0;
		{host_display_select_n, read_strobe_n, low_byte_write_n, high_byte_strobe_n} = 4'hF;
	end
	task automatic access(input logic wr, input logic mem, input logic hbe_n, input logic [16:0] a,
		input logic [15:0] wd, output logic [15:0] rd, output logic ok);
		int n;
		ok = 1'b0;
		rd = 16'hXXXX;
		@(posedge sys_clk);
		#1;
		host_address_in = a;
		mem_reg_sel = mem;
		high_byte_strobe_n = hbe_n;
		host_data_bus_in = wr ? wd : ~host_data_bus_in;
		host_display_select_n = 1'b0;
		read_strobe_n = wr;
		low_byte_write_n = !wr;
		// Pins are looked at just after the edge, never in the edge's own time step
		for (n = 0; n < 8 && host_wait !== pol; n++)
		begin
			@(posedge sys_clk);
			#1;
		end
		if (host_wait === pol)
		begin
			for (n = 0; n < 60 && host_wait === pol; n++)
			begin
				@(posedge sys_clk);
				#1;
			end
			ok = (host_wait === !pol);
			rd = host_data_bus_oe ? host_data_bus_out : 16'hXXXX;
		end
		#1;
		{host_display_select_n, read_strobe_n, low_byte_write_n} = 3'h7;
		// Released bus must not keep the old value
		host_data_bus_in = ~host_data_bus_in;
		repeat (4) @(posedge sys_clk);
	endtask : access
endmodule : host_bus_model

// ---- isa_style_host_bus_slave_bench.sv ----
/* Self-checking bench for host_bus_slave driven by host_bus_model.
   Assumes the bound monitor watches the pins alongside. */
`timescale 1ns/10ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin mismatches++; \
	$display("[ERR] %0t got %h expected %h", $time, got, exp); end end
module isa_style_host_bus_slave_bench;
	logic sys_clk, rstn, endian_strap, stall_polarity_strap, bus_start_in, rw_dir_in, mem, cs_n, rd_n, wr_n;
	logic hbe_n, oe, hwait, enabled, ok;
	logic [2:0]  bus_mode_straps;
	logic [16:0] addr;
	logic [15:0] din, dout, rd;
	int mismatches, comparisons;
	host_bus_model host_bus_model_i (.sys_clk, .pol(stall_polarity_strap), .host_wait(hwait),
		.host_data_bus_out(dout), .host_data_bus_oe(oe), .host_address_in(addr), .mem_reg_sel(mem),
		.host_display_select_n(cs_n), .read_strobe_n(rd_n), .low_byte_write_n(wr_n),
		.high_byte_strobe_n(hbe_n), .host_data_bus_in(din));
	host_bus_slave #(.REFRESH_CYCLES(4)) host_bus_slave_i (.sys_clk, .rstn, .bus_mode_straps, .endian_strap,
		.stall_polarity_strap, .bclk_div_straps(2'h0), .host_address_in(addr), .mem_reg_sel(mem),
		.host_display_select_n(cs_n), .read_strobe_n(rd_n), .low_byte_write_n(wr_n),
		.high_byte_strobe_n(hbe_n), .bus_start_in, .rw_dir_in, .host_data_bus_in(din),
		.host_data_bus_out(dout), .host_data_bus_oe(oe), .host_wait(hwait), .port_enabled(enabled),
		.bclk_tick());
	initial
	begin
		sys_clk = 1'b0;
		forever #5 sys_clk = ~sys_clk;
	end
	task automatic end_sim();
		$display("mismatches %0d comparisons %0d", mismatches, comparisons);
		if (mismatches == 0 && comparisons > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : end_sim
	task automatic boot(input logic [2:0] mode, input logic endian, input logic pol);
		@(posedge sys_clk);
		#1;
		rstn = 1'b0;
		{bus_mode_straps, endian_strap, stall_polarity_strap} = {mode, endian, pol};
		repeat (12) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		repeat (3) @(posedge sys_clk);
	endtask : boot
	task automatic put(input logic mem_q, input logic hb, input logic [16:0] a, input logic [15:0] wd);
		host_bus_model_i.access(1'b1, mem_q, hb, a, wd, rd, ok);
		`CHK(ok, 1'b1)
	endtask : put
	task automatic get(input logic mem_q, input logic hb, input logic [16:0] a, input logic [15:0] exp);
		host_bus_model_i.access(1'b0, mem_q, hb, a, 16'h0000, rd, ok);
		`CHK(ok, 1'b1)
		`CHK(rd, exp)
	endtask : get
	// ************************************************************
	// Scenarios
	// ************************************************************
	task automatic test_spaces();
		boot(3'h4, 1'b0, 1'b0);
		{bus_start_in, rw_dir_in} = 2'h0;
		put(1'b0, 1'b0, 17'h00010, 16'h5A5A);
		put(1'b1, 1'b0, 17'h00010, 16'h1234);
		get(1'b0, 1'b0, 17'h00010, 16'h5A5A);
		get(1'b1, 1'b0, 17'h00010, 16'h1234);
		{bus_start_in, rw_dir_in} = 2'h3;
	endtask : test_spaces
	task automatic test_lanes();
		put(1'b1, 1'b0, 17'h1FFFE, 16'h1234);
		put(1'b1, 1'b1, 17'h1FFFE, 16'hFFCD);
		get(1'b1, 1'b0, 17'h1FFFE, 16'h12CD);
		get(1'b1, 1'b1, 17'h1FFFF, 16'h1212);
	endtask : test_lanes
	task automatic test_polarity();
		boot(3'h4, 1'b0, 1'b1);
		put(1'b0, 1'b0, 17'h0001E, 16'hC3A5);
		get(1'b0, 1'b0, 17'h0001E, 16'hC3A5);
	endtask : test_polarity
	task automatic test_disabled();
		logic [3:0] bad [2] = '{4'h0, 4'h9};
		foreach (bad[i])
		begin
			boot(bad[i][3:1], bad[i][0], 1'b0);
			`CHK(enabled, 1'b0)
			host_bus_model_i.access(1'b0, 1'b0, 1'b0, 17'h00000, 16'h0000, rd, ok);
			`CHK(ok, 1'b0)
		end
	endtask : test_disabled
	initial
	begin
		{rstn, bus_mode_straps, endian_strap, stall_polarity_strap} = 6'h20;
		{bus_start_in, rw_dir_in} = 2'h3;
		mismatches = 0;
		comparisons = 0;
		test_spaces();
		test_lanes();
		test_polarity();
		test_disabled();
		end_sim();
	end
	initial
	begin
		#200000;
		mismatches++;
		end_sim();
	end
endmodule : isa_style_host_bus_slave_bench
